// file: rtl/pmd_frame_engine.sv
`timescale 1ns/1ps
module pmd_frame_engine
    import pmd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic mdc_rise,
    input wire logic mdc_fall,
    input wire logic mdio_sync,
    output logic mdio_out,
    output logic mdio_oe,
    pmd_link_if.engine lk
);
    typedef struct packed {
        pmd_eng_phase_type phase;
        logic [CNT_W-1:0] cnt;
        logic [FRAME_W-1:0] shift;
        logic rd;
        logic [DATA_W-1:0] rx;
        logic oe;
        logic dout;
        logic done;
    } pmd_eng_state_type;

    pmd_eng_state_type s;
    pmd_eng_state_type next_s;
    logic [CNT_W-1:0] cnt_inc;

    assign cnt_inc = s.cnt + 6'h01;

    // ------------------------------------------------------------
    // frame shifter: drive after fall, sample on rise
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'h0;
        case (s.phase)
            ENG_IDLE: begin
                if (lk.start) begin
                    next_s.phase = ENG_WAIT;
                    next_s.rd = lk.is_read;
                    next_s.shift = {PREAMBLE, FRAME_START,
                        lk.is_read ? OP_READ : OP_WRITE,
                        lk.phy_addr, lk.reg_addr, TURNAROUND,
                        lk.is_read ? DATA_RESET : lk.wdata};
                end
            end
            ENG_WAIT: begin
                if (mdc_fall) begin
                    next_s.phase = ENG_RUN;
                    next_s.cnt = '0;
                    next_s.oe = 1'h1;
                    next_s.dout = s.shift[FRAME_W-1];
                end
            end
            ENG_RUN: begin
                if (mdc_rise) begin
                    if (s.rd && s.cnt >= FIRST_READ_DATA) begin
                        next_s.rx = {s.rx[DATA_W-2:0], mdio_sync};
                    end
                    if (s.cnt == LAST_BIT) begin
                        next_s.phase = ENG_IDLE;
                        next_s.oe = 1'h0;
                        next_s.dout = 1'h0;
                        next_s.done = 1'h1;
                    end
                end else if (mdc_fall) begin
                    next_s.cnt = cnt_inc;
                    next_s.shift = {s.shift[FRAME_W-2:0], 1'h0};
                    next_s.dout = s.shift[FRAME_W-2];
                    next_s.oe = !(s.rd && cnt_inc > LAST_DRIVEN_READ);
                end
            end
            default: begin
                next_s.phase = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign lk.busy = (s.phase != ENG_IDLE);
    assign lk.done = s.done;
    assign lk.rdata = s.rx;
    assign mdio_out = s.dout;
    assign mdio_oe = s.oe;
endmodule

// file: rtl/pmd_mgmt_top.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
// Contract
// - writing write data launches one management write with that value
// - a finished read places the returned 16 bits in read data
// - bit 3 shows link fail from the last phy status read
// - bit 2 reads one while a read has not yet completed
// - bit 1 reads one while continuous scan reads are in progress
// - bit 0 reads one while a read or write cycle runs
// - unimplemented upper bits of these registers read as zero
// - read command does one read; otherwise write uses write data
// - scan command repeats reads until cleared
// - cycles carry 5-bit phy and register addresses; phy zero reserved
module pmd_mgmt_top
    import pmd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    output logic irq
);
    typedef struct packed {
        pmd_ctl_phase_type phase;
        logic cur_read;
        logic cmd_read;
        logic cmd_scan;
        logic [ADR_FIELD_W-1:0] phy_select;
        logic [ADR_FIELD_W-1:0] phy_reg_select;
        logic [DATA_W-1:0] mgmt_wr_value;
        logic [DATA_W-1:0] mgmt_rd_value;
        logic link_down_flag;
        logic rd_pending_flag;
        logic wr_req;
        logic rd_req;
        logic [INT_W-1:0] int_status;
        logic [INT_W-1:0] int_mask;
        logic [31:0] rdata;
    } pmd_top_state_type;

    pmd_top_state_type s;
    pmd_top_state_type next_s;

    pmd_link_if lk ();

    logic mdc_rise;
    logic mdc_fall;
    logic mdio_sync;
    logic setup;
    logic access;
    logic wr_en;
    logic mapped;
    logic mgmt_active_flag;
    logic scanning;
    logic phy_ok;
    logic go_write;
    logic go_read;
    logic new_link_down;
    logic [INT_W-1:0] int_set;
    logic [31:0] read_mux;

    // ------------------------------------------------------------
    // pin synchroniser and frame engine
    // ------------------------------------------------------------
    pmd_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .mdc(mdc),
        .mdio_in(mdio_in),
        .mdc_rise(mdc_rise),
        .mdc_fall(mdc_fall),
        .mdio_sync(mdio_sync)
    );

    pmd_frame_engine u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .mdc_rise(mdc_rise),
        .mdc_fall(mdc_fall),
        .mdio_sync(mdio_sync),
        .mdio_out(mdio_out),
        .mdio_oe(mdio_oe),
        .lk(lk.engine)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = access;
    assign wr_en = access & pwrite & mapped;

    always_comb begin
        case (paddr)
            OFS_COMMAND,
            OFS_ADDRESS,
            OFS_WRITE_DATA,
            OFS_READ_DATA,
            OFS_INDICATORS,
            OFS_INT_STATUS,
            OFS_INT_MASK: mapped = 1'h1;
            default: mapped = 1'h0;
        endcase
    end

    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------
    // indicators
    // ------------------------------------------------------------
    assign mgmt_active_flag = (s.phase == CTL_RUN) | lk.busy
        | s.wr_req | s.rd_req;
    assign scanning = s.cmd_scan;

    // ------------------------------------------------------------
    // read data mux, upper bits zero
    // ------------------------------------------------------------
    always_comb begin
        read_mux = '0;
        case (paddr)
            OFS_COMMAND: begin
                read_mux[CMD_READ_BIT] = s.cmd_read;
                read_mux[CMD_SCAN_BIT] = s.cmd_scan;
            end
            OFS_ADDRESS: begin
                read_mux[ADR_PHY_LSB +: ADR_FIELD_W] = s.phy_select;
                read_mux[ADR_REG_LSB +: ADR_FIELD_W] = s.phy_reg_select;
            end
            OFS_WRITE_DATA: begin
                read_mux[DATA_W-1:0] = s.mgmt_wr_value;
            end
            OFS_READ_DATA: begin
                read_mux[DATA_W-1:0] = s.mgmt_rd_value;
            end
            OFS_INDICATORS: begin
                read_mux[IND_LINK_BIT] = s.link_down_flag;
                read_mux[IND_PEND_BIT] = s.rd_pending_flag;
                read_mux[IND_SCAN_BIT] = scanning;
                read_mux[IND_BUSY_BIT] = mgmt_active_flag;
            end
            OFS_INT_STATUS: begin
                read_mux[INT_W-1:0] = s.int_status;
            end
            OFS_INT_MASK: begin
                read_mux[INT_W-1:0] = s.int_mask;
            end
            default: begin
                read_mux = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // cycle launch
    // ------------------------------------------------------------
    assign phy_ok = (s.phy_select != PHY_ADDR_RESERVED);
    assign go_write = (s.phase == CTL_IDLE) & ~lk.busy & s.wr_req & phy_ok;
    assign go_read = (s.phase == CTL_IDLE) & ~lk.busy & ~s.wr_req
        & (s.rd_req | s.cmd_scan) & phy_ok;

    assign lk.start = go_write | go_read;
    assign lk.is_read = go_read;
    assign lk.phy_addr = s.phy_select;
    assign lk.reg_addr = s.phy_reg_select;
    assign lk.wdata = s.mgmt_wr_value;

    assign new_link_down = ~lk.rdata[LINK_OK_BIT];

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        int_set = '0;

        if (setup) begin
            next_s.rdata = read_mux;
        end

        case (s.phase)
            CTL_IDLE: begin
                if (go_write) begin
                    next_s.phase = CTL_RUN;
                    next_s.cur_read = 1'h0;
                    next_s.wr_req = 1'h0;
                end else if (go_read) begin
                    next_s.phase = CTL_RUN;
                    next_s.cur_read = 1'h1;
                    next_s.rd_req = 1'h0;
                    next_s.rd_pending_flag = 1'h1;
                end else if (!phy_ok) begin
                    // reserved phy address: requests are dropped
                    next_s.wr_req = 1'h0;
                    next_s.rd_req = 1'h0;
                    next_s.rd_pending_flag = 1'h0;
                end
            end
            CTL_RUN: begin
                if (lk.done) begin
                    next_s.phase = CTL_IDLE;
                    if (s.cur_read) begin
                        next_s.mgmt_rd_value = lk.rdata;
                        next_s.rd_pending_flag = 1'h0;
                        int_set[INT_READ_DONE] = 1'h1;
                        if (s.phy_reg_select == PHY_STATUS_REG) begin
                            next_s.link_down_flag = new_link_down;
                            int_set[INT_LINK_FAIL] = new_link_down
                                & ~s.link_down_flag;
                        end
                    end else begin
                        int_set[INT_WRITE_DONE] = 1'h1;
                    end
                end
            end
            default: begin
                next_s.phase = CTL_IDLE;
            end
        endcase

        if (wr_en) begin
            case (paddr)
                OFS_COMMAND: begin
                    next_s.cmd_read = pwdata[CMD_READ_BIT];
                    next_s.cmd_scan = pwdata[CMD_SCAN_BIT];
                    if (pwdata[CMD_READ_BIT] && !s.cmd_read) begin
                        next_s.rd_req = 1'h1;
                        next_s.rd_pending_flag = 1'h1;
                    end
                end
                OFS_ADDRESS: begin
                    next_s.phy_select =
                        pwdata[ADR_PHY_LSB +: ADR_FIELD_W];
                    next_s.phy_reg_select =
                        pwdata[ADR_REG_LSB +: ADR_FIELD_W];
                end
                OFS_WRITE_DATA: begin
                    next_s.mgmt_wr_value = pwdata[DATA_W-1:0];
                    next_s.wr_req = 1'h1;
                end
                OFS_READ_DATA: begin
                    next_s.mgmt_rd_value = pwdata[DATA_W-1:0];
                end
                OFS_INT_MASK: begin
                    next_s.int_mask = pwdata[INT_W-1:0];
                end
                default: begin
                    next_s.int_mask = s.int_mask;
                end
            endcase
        end

        // write one to clear, a new event wins
        if (wr_en && paddr == OFS_INT_STATUS) begin
            next_s.int_status = (s.int_status & ~pwdata[INT_W-1:0])
                | int_set;
        end else begin
            next_s.int_status = s.int_status | int_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.phy_select <= PHY_ADDR_RESET;
            s.phy_reg_select <= REG_ADDR_RESET;
            s.phase <= CTL_IDLE;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = s.rdata;
    assign irq = |(s.int_status & s.int_mask);
endmodule

// file: rtl/pmd_pin_sync.sv
`timescale 1ns/1ps
module pmd_pin_sync
    import pmd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdc_rise,
    output logic mdc_fall,
    output logic mdio_sync
);
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
        logic mdc_prev;
    } pmd_sync_state_type;

    pmd_sync_state_type s;
    pmd_sync_state_type next_s;

    // ------------------------------------------------------------
    // two flops per pin plus a third on mdc, edges found by comparing the second stage with the third
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.meta = {mdio_in, mdc};
        next_s.stable = s.meta;
        next_s.mdc_prev = s.stable[0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign mdc_rise = s.stable[0] & ~s.mdc_prev;
    assign mdc_fall = ~s.stable[0] & s.mdc_prev;
    assign mdio_sync = s.stable[1];
endmodule

// file: shared/pmd_link_if.sv
`timescale 1ns/1ps
interface pmd_link_if;
    logic start;
    logic is_read;
    logic [4:0] phy_addr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
    logic busy;
    logic done;
    logic [15:0] rdata;

    modport ctrl (
        output start,
        output is_read,
        output phy_addr,
        output reg_addr,
        output wdata,
        input busy,
        input done,
        input rdata
    );

    modport engine (
        input start,
        input is_read,
        input phy_addr,
        input reg_addr,
        input wdata,
        output busy,
        output done,
        output rdata
    );
endinterface

// file: shared/pmd_pkg.sv
package pmd_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the apb bus)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ADDRESS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_WRITE_DATA = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_READ_DATA = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_INDICATORS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h18;

    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam int CMD_READ_BIT = 0;
    localparam int CMD_SCAN_BIT = 1;
    localparam int ADR_REG_LSB = 0;
    localparam int ADR_PHY_LSB = 8;
    localparam int ADR_FIELD_W = 5;
    localparam int DATA_W = 16;
    localparam int IND_BUSY_BIT = 0;
    localparam int IND_SCAN_BIT = 1;
    localparam int IND_PEND_BIT = 2;
    localparam int IND_LINK_BIT = 3;
    localparam int INT_W = 3;
    localparam int INT_WRITE_DONE = 0;
    localparam int INT_READ_DONE = 1;
    localparam int INT_LINK_FAIL = 2;
    localparam logic [ADR_FIELD_W-1:0] PHY_ADDR_RESET = 5'h01;
    localparam logic [ADR_FIELD_W-1:0] PHY_ADDR_RESERVED = 5'h00;
    localparam logic [ADR_FIELD_W-1:0] REG_ADDR_RESET = 5'h00;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    // ------------------------------------------------------------
    // management frame layout
    // ------------------------------------------------------------
    localparam int FRAME_W = 64;
    localparam int CNT_W = 6;
    localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
    localparam logic [1:0] FRAME_START = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] TURNAROUND = 2'h2;
    localparam logic [CNT_W-1:0] LAST_DRIVEN_READ = 6'h2D;
    localparam logic [CNT_W-1:0] FIRST_READ_DATA = 6'h30;
    localparam logic [CNT_W-1:0] LAST_BIT = 6'h3F;
    localparam logic [ADR_FIELD_W-1:0] PHY_STATUS_REG = 5'h01;
    localparam int LINK_OK_BIT = 2;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ENG_IDLE,
        ENG_WAIT,
        ENG_RUN
    } pmd_eng_phase_type;

    typedef enum logic {
        CTL_IDLE,
        CTL_RUN
    } pmd_ctl_phase_type;

endpackage

// file: sim/phy_mgmt_data_status_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module phy_mgmt_data_status_tb
    import pmd_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, err, mdc, mdio_in, mdio_out, mdio_oe, irq;
    logic [63:0] frame, ef;
    logic [15:0] reply = '0;
    int frames, mismatches = 0, num_checks = 0, cyc = 0;
    always #50 pclk = ~pclk;
    pmd_mgmt_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq(irq));
    pmd_phy_model phy (.run(run), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .reply(reply), .mdc(mdc), .mdio_in(mdio_in), .frame(frame),
        .frames(frames));
    // ------------------------------------------------------------
    // bus tasks and expected frame
    // ------------------------------------------------------------
    function automatic logic [63:0] mk(input logic [1:0] op,
        input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        return {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, d};
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic wait_idle();
        int n = 0;
        run <= 1'b1;
        do begin
            apb(1'b0, OFS_INDICATORS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 600);
        run <= 1'b0;
        `CHK(q[0], 1'b0)
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [4:0] pa;
        logic [4:0] ra;
        logic [31:0] wv;
        int f0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        void'($urandom(5));
        for (int i = 0; i < 7; i++) rdc(8'(4 * i), i == 1 ? 32'h100 : 32'h0);
        rdc(8'h1C, 32'h0);
        `CHK(err, 1'b1)
        $display("test reset done");
        pa = 5'(1 + $urandom % 31);
        ra = 5'($urandom % 32);
        wv = $urandom;
        apb(1'b1, OFS_ADDRESS, {19'h0, pa, 3'h0, ra});
        apb(1'b1, OFS_INT_MASK, 32'h7);
        f0 = frames;
        apb(1'b1, OFS_WRITE_DATA, wv);
        rdc(OFS_INDICATORS, 32'h1);
        rdc(OFS_WRITE_DATA, {16'h0, wv[15:0]});
        wait_idle();
        `CHK(frames, f0 + 1)
        `CHK(frame, mk(OP_WRITE, pa, ra, wv[15:0]))
        `CHK(irq, 1'b1)
        rdc(OFS_INT_STATUS, 32'h1);
        $display("test write done");
        for (int k = 0; k < 2; k++) begin
            pa = 5'(1 + $urandom % 31);
            reply = 16'($urandom);
            reply[2] = k[0];
            apb(1'b1, OFS_ADDRESS, {19'h0, pa, 8'h01});
            apb(1'b1, OFS_COMMAND, 32'h1);
            rdc(OFS_INDICATORS, k == 1 ? 32'hD : 32'h5);
            wait_idle();
            ef = mk(OP_READ, pa, 5'h01, reply);
            `CHK({frame[63:18], frame[16:0]}, {ef[63:18], 1'b0, reply})
            rdc(OFS_READ_DATA, {16'h0, reply});
            rdc(OFS_INDICATORS, k == 1 ? 32'h0 : 32'h8);
            apb(1'b1, OFS_COMMAND, 32'h0);
        end
        $display("test read done");
        reply = 16'h0004;
        apb(1'b1, OFS_COMMAND, 32'h2);
        apb(1'b0, OFS_INDICATORS, 32'h0);
        `CHK(q[1], 1'b1)
        f0 = frames;
        run <= 1'b1;
        for (int n = 0; n < 3000 && frames < f0 + 2; n++) @(posedge pclk);
        `CHK(frames >= f0 + 2, 1'b1)
        apb(1'b1, OFS_COMMAND, 32'h0);
        wait_idle();
        rdc(OFS_INDICATORS, 32'h0);
        rdc(OFS_READ_DATA, 32'h4);
        $display("test scan done");
        apb(1'b1, OFS_ADDRESS, 32'h5);
        f0 = frames;
        apb(1'b1, OFS_WRITE_DATA, 32'h1234);
        run <= 1'b1;
        repeat (200) @(posedge pclk);
        run <= 1'b0;
        `CHK(frames, f0)
        rdc(OFS_INDICATORS, 32'h0);
        $display("test reserved phy done");
        apb(1'b1, OFS_INT_MASK, 32'h0);
        `CHK(irq, 1'b0)
        rdc(OFS_INT_STATUS, 32'h7);
        apb(1'b1, OFS_INT_MASK, 32'h4);
        `CHK(irq, 1'b1)
        apb(1'b1, OFS_INT_STATUS, 32'h7);
        `CHK(irq, 1'b0)
        rdc(OFS_INT_STATUS, 32'h0);
        ce <= 1'b0;
        apb(1'b1, OFS_INT_MASK, 32'h1);
        ce <= 1'b1;
        rdc(OFS_INT_MASK, 32'h4);
        $display("test interrupt done");
        complete_run();
    end
endmodule
bind pmd_mgmt_top pmd_mgmt_asserts chk (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .irq(irq));

// file: sim/pmd_mgmt_top_asserts.sv
`timescale 1ns/1ps
module pmd_mgmt_asserts
    import pmd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic [4:0] phy_sh;
    assign acc = psel && penable;
    // shadow of the selected phy address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_sh <= PHY_ADDR_RESET;
        end else if (acc && pwrite && paddr == OFS_ADDRESS) begin
            phy_sh <= pwdata[12:8];
        end
    end
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    a_ready_follows: assert property (pready == acc)
        else $error("ready not tied to access");
    a_bad_addr_err: assert property (acc && paddr > OFS_INT_MASK |-> pslverr)
        else $error("no error on unmapped address");
    a_good_addr_ok: assert property (acc && paddr <= OFS_INT_MASK
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped");
    a_upper_zero: assert property (acc && !pwrite |->
        prdata[31:16] == 16'h0000) else $error("upper read bits set");
    a_ind_upper_zero: assert property (acc && !pwrite &&
        paddr == OFS_INDICATORS |-> prdata[31:4] == 28'h0)
        else $error("indicator upper bits set");
    a_irq_masked_off: assert property (acc && pwrite && paddr == OFS_INT_MASK
        && pwdata[2:0] == 3'h0 |=> !irq) else $error("irq while masked");
    // ------------------------------------------------------------
    // management link
    // ------------------------------------------------------------
    a_phy_zero_quiet: assert property (acc && pwrite &&
        paddr == OFS_WRITE_DATA && phy_sh == PHY_ADDR_RESERVED && !mdio_oe
        |=> !mdio_oe [*8]) else $error("frame to reserved phy");
    a_first_bit_one: assert property ($rose(mdio_oe) |-> mdio_out)
        else $error("frame not opened by preamble");
    a_start_on_fall: assert property ($rose(mdio_oe) |->
        !mdc && !$past(mdc)) else $error("drive began off a link fall");
    a_bit_after_fall: assert property ($changed(mdio_out) && mdio_oe
        && $past(mdio_oe) |-> !mdc && !$past(mdc))
        else $error("bit changed off a link fall");
    a_oe_hold_bit: assert property ($rose(mdio_oe) |=> mdio_oe [*8])
        else $error("drive shorter than a bit");
    c_write_data: cover property (acc && pwrite && paddr == OFS_WRITE_DATA);
    c_frame_start: cover property ($rose(mdio_oe));
    c_irq_rise: cover property ($rose(irq));
    c_bad_addr: cover property (acc && pslverr);
endmodule

// file: sim/pmd_phy_model.sv
`timescale 1ns/1ps
module pmd_phy_model (
    input wire logic run,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic [15:0] reply,
    output logic mdc,
    output logic mdio_in,
    output logic [63:0] frame,
    output int frames
);
    logic [63:0] sh = '0;
    int cnt = 0;
    logic rd = 1'b0;
    initial begin
        mdc = 1'b0;
        mdio_in = 1'b1;
        frame = '0;
        frames = 0;
    end
    // link clock stands still unless a frame is wanted
    always begin
        #400;
        mdc = run ? ~mdc : 1'b0;
    end
    // capture on rise, op code decides whether to answer
    always @(posedge mdc) begin
        if (cnt != 0 || mdio_oe) begin
            sh = {sh[62:0], mdio_oe ? mdio_out : mdio_in};
            cnt++;
            if (cnt == 36) rd = (sh[1:0] == 2'b10);
            if (cnt == 64) begin
                frame = sh;
                frames++;
                cnt = 0;
                rd = 1'b0;
            end
        end
    end
    // turnaround low, data msb first, else a changing level
    always @(negedge mdc) begin
        if (rd && cnt == 47) mdio_in = 1'b0;
        else if (rd && cnt >= 48) mdio_in = reply[63-cnt];
        else mdio_in = ~mdio_in;
    end
endmodule
